// >>> design/eps_top.sv
// enhanced pwm shutdown, delay and steering logic with apb registers
`timescale 1ns/1ps
module eps_top
  import eps_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pwm_raw,
  input  wire logic        period_start_timer_two,
  input  wire logic        period_start_timer_four,
  input  wire logic        fault_input_n,
  input  wire logic        comparator_one_output,
  input  wire logic        comparator_two_output,
  input  wire logic [3:0]  port_out,
  input  wire logic [3:0]  port_oe,
  output logic             enhanced_output_a,
  output logic             enhanced_output_a_oe,
  output logic             enhanced_output_b,
  output logic             enhanced_output_b_oe,
  output logic             enhanced_output_c,
  output logic             enhanced_output_c_oe,
  output logic             enhanced_output_d,
  output logic             enhanced_output_d_oe,
  output logic             shutdown_event_flag,
  output logic             channel_one_timer_select,
  output logic             channel_two_timer_select,
  output logic             channel_three_timer_select
);

  // ==========================================================
  // registers
  logic [15:0] shutdown_reg;
  logic [15:0] delay_reg;
  logic [15:0] steer_reg;
  logic [15:0] timersel_reg;
  logic [15:0] mode_reg;
  logic [15:0] next_shutdown_reg;
  logic [15:0] next_delay_reg;
  logic [15:0] next_steer_reg;
  logic [15:0] next_timersel_reg;
  logic [15:0] next_mode_reg;
  logic [31:0] next_prdata;
  logic        addr_hit;
  logic        wr_strobe;
  logic [15:0] wdata;
  logic [15:0] rd_value;

  // ==========================================================
  // derived controls
  logic [2:0]  shutdown_source_select;
  logic [1:0]  ac_pair_shutdown_state;
  logic [1:0]  bd_pair_shutdown_state;
  logic        auto_restart_enable;
  logic [6:0]  pwm_delay_count;
  logic [3:0]  enhanced_mode_field;
  logic [1:0]  output_configuration_field;
  logic        steering_update_sync;
  logic        src_active;
  logic        period_start;
  logic        pwm_mode;

  assign shutdown_source_select = shutdown_reg[SRC_LSB +: 3];
  assign ac_pair_shutdown_state = shutdown_reg[AC_LSB +: 2];
  assign bd_pair_shutdown_state = shutdown_reg[BD_LSB +: 2];
  assign auto_restart_enable    = delay_reg[RESTART_BIT];
  assign pwm_delay_count        = delay_reg[DELAY_W-1:0];
  assign enhanced_mode_field    = mode_reg[3:0];
  assign output_configuration_field = mode_reg[PM_LSB +: 2];
  assign steering_update_sync   = steer_reg[SYNC_BIT];
  assign pwm_mode = (enhanced_mode_field[3:2] == MODE_PWM_HI);
  assign shutdown_event_flag    = shutdown_reg[FLAG_BIT];
  assign channel_one_timer_select   = timersel_reg[TSEL1_BIT];
  assign channel_two_timer_select   = timersel_reg[TSEL2_BIT];
  assign channel_three_timer_select = timersel_reg[TSEL3_BIT];

  // channel one's period boundary follows its chosen time base
  assign period_start = channel_one_timer_select ?
                        period_start_timer_four :
                        period_start_timer_two; // R17

  // ==========================================================
  // shutdown source selection, level sensitive
  always_comb begin
    case (shutdown_source_select)
      SRC_OFF:        src_active = 1'b0; // R2
      SRC_CMP1:       src_active = comparator_one_output; // R3
      SRC_CMP2:       src_active = comparator_two_output; // R3
      SRC_CMP_EITHER: src_active = comparator_one_output |
                                   comparator_two_output; // R3
      SRC_FAULT:      src_active = ~fault_input_n; // R2
      SRC_FAULT_C1:   src_active = ~fault_input_n |
                                   comparator_one_output; // R2
      SRC_FAULT_C2:   src_active = ~fault_input_n |
                                   comparator_two_output; // R2
      SRC_FAULT_ANY:  src_active = ~fault_input_n |
                                   comparator_one_output |
                                   comparator_two_output; // R2
      default:        src_active = 1'b0;
    endcase
  end

  // ==========================================================
  // apb slave: zero wait states, read data caught in setup
  assign wr_strobe = psel & penable & pwrite;
  assign wdata     = pwdata[15:0];
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    case (paddr)
      OFS_SHUTDOWN: rd_value = shutdown_reg;
      OFS_DELAY:    rd_value = delay_reg;
      OFS_STEER:    rd_value = steer_reg;
      OFS_TIMERSEL: rd_value = timersel_reg;
      OFS_MODE:     rd_value = mode_reg;
      default: begin
        rd_value = 16'h0000;
        addr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_prdata = prdata;
    if (psel & ~penable & ~pwrite) begin
      next_prdata = {16'h0000, rd_value}; // R20
    end
  end

  always_comb begin
    next_shutdown_reg = shutdown_reg;
    next_delay_reg    = delay_reg;
    next_steer_reg    = steer_reg;
    next_timersel_reg = timersel_reg;
    next_mode_reg     = mode_reg;
    if (wr_strobe) begin
      case (paddr)
        OFS_SHUTDOWN: begin
          // flag bit takes the written value only while no source is active
          next_shutdown_reg = wdata & MSK_SHUTDOWN; // R20
          next_shutdown_reg[FLAG_BIT] = shutdown_reg[FLAG_BIT];
          if (!src_active) begin
            next_shutdown_reg[FLAG_BIT] = wdata[FLAG_BIT]; // R7 R10
          end
        end
        OFS_DELAY:    next_delay_reg    = wdata & MSK_DELAY; // R20
        OFS_STEER:    next_steer_reg    = wdata & MSK_STEER; // R20
        OFS_TIMERSEL: next_timersel_reg = wdata & MSK_TIMERSEL; // R20
        OFS_MODE:     next_mode_reg     = wdata & MSK_MODE; // R20
        default: ;
      endcase
    end
    if (auto_restart_enable && !src_active &&
        shutdown_reg[FLAG_BIT]) begin
      next_shutdown_reg[FLAG_BIT] = 1'b0; // R9
    end
    // an active source always wins over any clear
    if (src_active) begin
      next_shutdown_reg[FLAG_BIT] = 1'b1; // R1 R6
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shutdown_reg <= RST_SHUTDOWN;
      delay_reg    <= RST_DELAY;
      steer_reg    <= RST_STEER;
      timersel_reg <= RST_TIMERSEL;
      mode_reg     <= RST_MODE;
      prdata       <= 32'h0000_0000;
    end else begin
      shutdown_reg <= next_shutdown_reg;
      delay_reg    <= next_delay_reg;
      steer_reg    <= next_steer_reg;
      timersel_reg <= next_timersel_reg;
      mode_reg     <= next_mode_reg;
      prdata       <= next_prdata;
    end
  end

  // ==========================================================
  // instruction cycle enable and restart gating
  logic icyc_phase;
  logic next_icyc_phase;
  logic icyc_en;
  logic run;
  logic next_run;

  assign icyc_en = icyc_phase;

  always_comb begin
    next_icyc_phase = ~icyc_phase; // R11
    // waveform only comes back on a period boundary
    next_run = run;
    if (shutdown_event_flag) begin
      next_run = 1'b0;
    end else if (period_start) begin
      next_run = 1'b1; // R8
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      icyc_phase <= 1'b0;
      run        <= 1'b0;
    end else begin
      icyc_phase <= next_icyc_phase;
      run        <= next_run;
    end
  end

  // ==========================================================
  // steering shadow, applied at the selected boundary
  logic [3:0] steer_act;
  logic [1:0] cmpl_act;
  logic [3:0] next_steer_act;
  logic [1:0] next_cmpl_act;
  logic       steer_load;

  assign steer_load = steering_update_sync ? period_start :
                      icyc_en; // R14

  always_comb begin
    next_steer_act = steer_act;
    next_cmpl_act  = cmpl_act;
    if (steer_load) begin
      next_steer_act = steer_reg[3:0];
      next_cmpl_act  = steer_reg[CMPL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      steer_act <= RST_STEER[3:0];
      cmpl_act  <= RST_STEER[CMPL_LSB +: 2];
    end else begin
      steer_act <= next_steer_act;
      cmpl_act  <= next_cmpl_act;
    end
  end

  // ==========================================================
  // active-edge delay for the true and inverted phases
  logic [1:0]         phase_raw;
  logic [1:0]         phase_act;

  assign phase_raw = {~pwm_raw, pwm_raw};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_delay
      logic [DELAY_W-1:0] dly_cnt;
      logic [DELAY_W-1:0] next_cnt;
      always_comb begin
        next_cnt = dly_cnt;
        if (!phase_raw[g]) begin
          next_cnt = pwm_delay_count; // R11
        end else if (icyc_en && dly_cnt != '0) begin
          next_cnt = dly_cnt - 7'h01; // R11
        end
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          dly_cnt <= '0;
        end else begin
          dly_cnt <= next_cnt;
        end
      end
      // inactive-going edges pass straight through
      assign phase_act[g] = phase_raw[g] &&
                            (dly_cnt == '0); // R11
    end
  endgenerate

  // ==========================================================
  // pin mapping: mode, steering, polarity and shutdown
  logic [3:0] pin_q;
  logic [3:0] pin_oe_q;
  logic [3:0] next_pin;
  logic [3:0] next_pin_oe;
  logic [3:0] pin_pwm;
  logic [3:0] pin_lvl;
  logic [3:0] pol_low;
  logic       in_shutdown;
  logic       mod_w;
  logic       cmp_w;

  assign mod_w = phase_act[0];
  assign cmp_w = phase_act[1];
  // a and c follow mode bit 1, b and d follow mode bit 0
  assign pol_low = {enhanced_mode_field[0], enhanced_mode_field[1],
                    enhanced_mode_field[0],
                    enhanced_mode_field[1]}; // R18
  assign in_shutdown = shutdown_event_flag | ~run;

  always_comb begin
    pin_pwm = 4'h0;
    pin_lvl = 4'h0;
    case (output_configuration_field)
      PM_SINGLE: begin
        // steering only honoured here and in pwm mode
        pin_pwm = steer_act; // R13 R15 R16 R19
        pin_lvl = {4{mod_w}}; // R15
        if (cmpl_act != CMPL_OFF) begin
          pin_pwm[0] = 1'b1; // R12
          pin_pwm[cmpl_act] = 1'b1; // R12
          pin_lvl[cmpl_act] = cmp_w; // R12
        end
      end
      PM_HALF: begin
        pin_pwm = 4'h3; // R19
        pin_lvl = {2'b00, cmp_w, mod_w}; // R19
      end
      PM_FORWARD: begin
        pin_pwm = 4'hf;
        pin_lvl = {mod_w, 2'b00, 1'b1};
      end
      PM_REVERSE: begin
        pin_pwm = 4'hf;
        pin_lvl = {1'b0, 1'b1, mod_w, 1'b0};
      end
      default: begin
        pin_pwm = 4'h0;
        pin_lvl = 4'h0;
      end
    endcase
    if (!pwm_mode) begin
      pin_pwm = 4'h0; // R16
    end
  end

  always_comb begin
    next_pin    = port_out;
    next_pin_oe = port_oe;
    for (int i = 0; i < 4; i++) begin
      if (pin_pwm[i]) begin
        next_pin_oe[i] = 1'b1;
        next_pin[i]    = pin_lvl[i] ^ pol_low[i]; // R15 R18
        if (in_shutdown) begin
          if (i == 0 || i == 2) begin
            next_pin_oe[i] = ~ac_pair_shutdown_state[1]; // R4
            next_pin[i]    = ac_pair_shutdown_state[0]; // R4
          end else begin
            next_pin_oe[i] = ~bd_pair_shutdown_state[1]; // R5
            next_pin[i]    = bd_pair_shutdown_state[0]; // R5
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_q    <= 4'h0;
      pin_oe_q <= 4'h0;
    end else begin
      pin_q    <= next_pin;
      pin_oe_q <= next_pin_oe;
    end
  end

  assign enhanced_output_a    = pin_q[0];
  assign enhanced_output_a_oe = pin_oe_q[0];
  assign enhanced_output_b    = pin_q[1];
  assign enhanced_output_b_oe = pin_oe_q[1];
  assign enhanced_output_c    = pin_q[2];
  assign enhanced_output_c_oe = pin_oe_q[2];
  assign enhanced_output_d    = pin_q[3];
  assign enhanced_output_d_oe = pin_oe_q[3];

endmodule

// >>> design/eps_pkg.sv
// constants and register layout of the enhanced pwm output-steering block
// Behaviour
// R1 - shutdown event sets flag, forces shutdown state
// R2 - source field selects fault pin combinations
// R3 - codes 001-011 select comparator-only shutdown
// R4 - a/c pair shutdown state: tristate, high, low
// R5 - b/d pair shutdown state: tristate, high, low
// R6 - shutdown follows source level, not edges
// R7 - flag writes ignored while condition present
// R8 - restart only at next pwm period
// R9 - auto-restart clears flag when source inactive
// R10 - without auto-restart software clears the flag
// R11 - active-going edges delayed by instruction cycles
// R12 - complementary pair: a with b, c or d
// R13 - pair field 00 uses steering bits only
// R14 - steering update at period or instruction cycle
// R15 - steering bits route polarised pwm to pins
// R16 - steering only in pwm, single-output config
// R17 - timer select bit picks channel time base
// R18 - mode 1100-1111 set pair polarities
// R19 - half-bridge on a/b, single uses steering
// R20 - unimplemented bits read zero, ignore writes
package eps_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_SHUTDOWN = 12'h000;
  localparam logic [11:0] OFS_DELAY    = 12'h004;
  localparam logic [11:0] OFS_STEER    = 12'h008;
  localparam logic [11:0] OFS_TIMERSEL = 12'h00c;
  localparam logic [11:0] OFS_MODE     = 12'h010;

  // ==========================================================
  // implemented-bit masks
  localparam logic [15:0] MSK_SHUTDOWN = 16'h00ff;
  localparam logic [15:0] MSK_DELAY    = 16'h00ff;
  localparam logic [15:0] MSK_STEER    = 16'h00df;
  localparam logic [15:0] MSK_TIMERSEL = 16'h0049;
  localparam logic [15:0] MSK_MODE     = 16'h00cf;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_SHUTDOWN = 16'h0000;
  localparam logic [15:0] RST_DELAY    = 16'h0000;
  localparam logic [15:0] RST_STEER    = 16'h0001;
  localparam logic [15:0] RST_TIMERSEL = 16'h0000;
  localparam logic [15:0] RST_MODE     = 16'h0000;

  // ==========================================================
  // field positions
  localparam int FLAG_BIT    = 7;
  localparam int SRC_LSB     = 4;
  localparam int AC_LSB      = 2;
  localparam int BD_LSB      = 0;
  localparam int RESTART_BIT = 7;
  localparam int CMPL_LSB    = 6;
  localparam int SYNC_BIT    = 4;
  localparam int TSEL1_BIT   = 0;
  localparam int TSEL2_BIT   = 3;
  localparam int TSEL3_BIT   = 6;
  localparam int PM_LSB      = 6;

  // ==========================================================
  // encodings
  localparam logic [2:0] SRC_OFF       = 3'h0;
  localparam logic [2:0] SRC_CMP1      = 3'h1;
  localparam logic [2:0] SRC_CMP2      = 3'h2;
  localparam logic [2:0] SRC_CMP_EITHER = 3'h3;
  localparam logic [2:0] SRC_FAULT     = 3'h4;
  localparam logic [2:0] SRC_FAULT_C1  = 3'h5;
  localparam logic [2:0] SRC_FAULT_C2  = 3'h6;
  localparam logic [2:0] SRC_FAULT_ANY = 3'h7;
  localparam logic [1:0] MODE_PWM_HI   = 2'h3;
  localparam logic [1:0] PM_SINGLE     = 2'h0;
  localparam logic [1:0] PM_FORWARD    = 2'h1;
  localparam logic [1:0] PM_HALF       = 2'h2;
  localparam logic [1:0] PM_REVERSE    = 2'h3;
  localparam logic [1:0] CMPL_OFF      = 2'h0;

  // ==========================================================
  // timing
  localparam int ICYC_OSC_PERIODS = 2;
  localparam int DELAY_W          = 7;

endpackage

// >>> sim/eps_top_checker.sv
// assertion checker bound to the pwm shutdown and steering block
`timescale 1ns/1ps
module eps_top_checker
  import eps_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fault_input_n,
  input wire logic        comparator_one_output,
  input wire logic        comparator_two_output,
  input wire logic        shutdown_event_flag,
  input wire logic        channel_one_timer_select,
  input wire logic        channel_two_timer_select,
  input wire logic        channel_three_timer_select
);
  logic [2:0] src;
  logic [2:0] next_src;
  logic       restart;
  logic       next_restart;
  logic       acc;
  logic       wr_sd;
  logic       mapped;
  logic       act;
  // ==========================================================
  // shadow copies of the source select and restart bits
  assign acc    = psel & penable;
  assign wr_sd  = acc & pwrite & (paddr == OFS_SHUTDOWN);
  assign mapped = paddr inside {OFS_SHUTDOWN, OFS_DELAY, OFS_STEER,
                                OFS_TIMERSEL, OFS_MODE};
  assign act = (src[2] & ~fault_input_n) | (src[0] & comparator_one_output)
             | (src[1] & comparator_two_output);
  always_comb begin
    next_src     = src;
    next_restart = restart;
    if (wr_sd) next_src = pwdata[SRC_LSB +: 3];
    if (acc & pwrite & (paddr == OFS_DELAY)) next_restart = pwdata[7];
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src     <= 3'h0;
      restart <= 1'b0;
    end else begin
      src     <= next_src;
      restart <= next_restart;
    end
  end
  // ==========================================================
  // properties
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence s_shut;
    shutdown_event_flag && !restart && !wr_sd;
  endsequence
  // two quiet cycles span the one-cycle update of the flag register
  sequence s_gone;
    restart && shutdown_event_flag && !act && !wr_sd ##1 !act && !wr_sd;
  endsequence
  property p_flag_set;
    act |=> shutdown_event_flag;
  endproperty
  property p_flag_auto;
    s_gone |-> !shutdown_event_flag;
  endproperty
  property p_flag_hold;
    s_shut |=> shutdown_event_flag;
  endproperty
  property p_flag_swclr;
    wr_sd && !pwdata[FLAG_BIT] && !act |=> !shutdown_event_flag;
  endproperty
  property p_upper_zero;
    acc && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  property p_unmapped;
    acc && !pwrite && !mapped |-> prdata == 32'h0;
  endproperty
  property p_slverr;
    acc |-> pslverr == !mapped && pready;
  endproperty
  property p_tsel;
    acc && pwrite && paddr == OFS_TIMERSEL |=> channel_one_timer_select
      == $past(pwdata[0]) && channel_two_timer_select == $past(pwdata[3])
      && channel_three_timer_select == $past(pwdata[6]);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set by active source");
  a_flag_auto: assert property (p_flag_auto)
    else $error("flag not cleared by auto restart");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared without software");
  a_flag_swclr: assert property (p_flag_swclr)
    else $error("flag clear write not honoured");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_slverr: assert property (p_slverr)
    else $error("slave error wrong");
  a_tsel: assert property (p_tsel)
    else $error("timer select output wrong");
endmodule

bind eps_top eps_top_checker chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fault_input_n(fault_input_n),
  .comparator_one_output(comparator_one_output),
  .comparator_two_output(comparator_two_output),
  .shutdown_event_flag(shutdown_event_flag),
  .channel_one_timer_select(channel_one_timer_select),
  .channel_two_timer_select(channel_two_timer_select),
  .channel_three_timer_select(channel_three_timer_select)
);

// >>> sim/eps_bridge_model.sv
// fault sources and bridge gate-driver inputs facing the pwm pins
`timescale 1ns/1ps
module eps_bridge_model (
  input  wire logic       fault_req,
  input  wire logic       cmp1_req,
  input  wire logic       cmp2_req,
  input  wire logic [3:0] pin_lv,
  input  wire logic [3:0] pin_oe,
  output logic            fault_input_n,
  output logic            comparator_one_output,
  output logic            comparator_two_output,
  output logic [3:0]      gate_in
);
  // ==========================================================
  // sources and driver inputs
  assign fault_input_n         = ~fault_req;
  assign comparator_one_output = cmp1_req;
  assign comparator_two_output = cmp2_req;
  // gate inputs have pull-downs, so a released pin reads low
  assign gate_in = pin_oe & pin_lv;
endmodule

// >>> sim/eps_bench.sv
// self-checking bench for the pwm shutdown and steering block
`timescale 1ns/1ps
module enhanced_pwm_shutdown_steering_bench
  import eps_pkg::*;
;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        errv, pwm_raw, per2, per4, fault_req, cmp1_req, cmp2_req;
  logic        fault_n, cmp1, cmp2, flag, ts1, ts2, ts3, hit;
  logic [3:0]  port_out, port_oe, lv, oe, gate_in;
  logic [1:0]  ac, bd;
  int          fails = 0, comparisons = 0, cycles = 0;
  logic [11:0] ofs[4] = '{OFS_DELAY, OFS_STEER, OFS_TIMERSEL, OFS_MODE};
  logic [15:0] rst[4] = '{RST_DELAY, RST_STEER, RST_TIMERSEL, RST_MODE};
  logic [15:0] msk[4] = '{MSK_DELAY, MSK_STEER, MSK_TIMERSEL, MSK_MODE};
  logic [2:0]  trig[8] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h2, 3'h2, 3'h1, 3'h4};
  // ==========================================================
  // design and far side
  eps_top dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_raw(pwm_raw),
    .period_start_timer_two(per2), .period_start_timer_four(per4),
    .fault_input_n(fault_n), .comparator_one_output(cmp1),
    .comparator_two_output(cmp2), .port_out(port_out), .port_oe(port_oe),
    .enhanced_output_a(lv[0]), .enhanced_output_a_oe(oe[0]),
    .enhanced_output_b(lv[1]), .enhanced_output_b_oe(oe[1]),
    .enhanced_output_c(lv[2]), .enhanced_output_c_oe(oe[2]),
    .enhanced_output_d(lv[3]), .enhanced_output_d_oe(oe[3]),
    .shutdown_event_flag(flag), .channel_one_timer_select(ts1),
    .channel_two_timer_select(ts2), .channel_three_timer_select(ts3));
  eps_bridge_model far_u (
    .fault_req(fault_req), .cmp1_req(cmp1_req), .cmp2_req(cmp2_req),
    .pin_lv(lv), .pin_oe(oe), .fault_input_n(fault_n),
    .comparator_one_output(cmp1), .comparator_two_output(cmp2),
    .gate_in(gate_in));
  // ==========================================================
  // clock, timeout and tasks
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic pins(input logic [7:0] e);
    // look mid-cycle, once the pin registers have settled
    @(negedge clk_sys);
    chk({24'h0, oe, gate_in}, {24'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic pulse(input logic four);
    @(posedge clk_sys);
    per2 <= ~four;
    per4 <= four;
    @(posedge clk_sys);
    per2 <= 1'b0;
    per4 <= 1'b0;
  endtask
  // pin states of a shutdown, {oe d..a, level d..a}
  function automatic logic [7:0] sdp(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] o, l;
    o = {~b[1], ~a[1]};
    l = {b == 2'h1, a == 2'h1};
    return {o, o, l, l};
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pwm_raw, per2, per4, fault_req, cmp1_req, cmp2_req} = '0;
    port_out = 4'h0;
    port_oe  = 4'hf;
    resetn   = 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd(OFS_SHUTDOWN, {16'h0, RST_SHUTDOWN});
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], {16'h0, rst[i]});
      wr(ofs[i], 32'hffffffff);
      rd(ofs[i], {16'h0, msk[i]});
    end
    chk({29'h0, ts3, ts2, ts1}, 32'h7);
    wr(OFS_TIMERSEL, 32'h0);
    cyc(1);
    chk({29'h0, ts3, ts2, ts1}, 32'h0);
    wr(OFS_SHUTDOWN, 32'hffff007f);
    rd(OFS_SHUTDOWN, 32'h7f);
    xfer(1'b1, 12'h014, 32'hffffffff);
    chk({31'h0, errv}, 32'h1);
    rd(12'h014, 32'h0);
    chk({31'h0, errv}, 32'h1);
    wr(OFS_SHUTDOWN, 32'h0);
    wr(OFS_DELAY, 32'h0);
    wr(OFS_MODE, 32'h0d);
    wr(OFS_STEER, 32'h0f);
    pwm_raw  <= 1'b1;
    port_out <= 4'ha;
    pulse(1'b0);
    cyc(3);
    pins(8'hf5);
    port_oe <= 4'h7;
    wr(OFS_STEER, 32'h05);
    cyc(3);
    pins(8'h77);
    wr(OFS_STEER, 32'h1f);
    cyc(4);
    pins(8'h77);
    pulse(1'b0);
    cyc(3);
    pins(8'hf5);
    wr(OFS_MODE, 32'h8c);
    cyc(4);
    pins(8'h71);
    wr(OFS_MODE, 32'h4e);
    cyc(3);
    pins(8'hfc);
    wr(OFS_MODE, 32'hcf);
    cyc(3);
    pins(8'hf9);
    wr(OFS_MODE, 32'h0c);
    port_oe  <= 4'hf;
    port_out <= 4'hf;
    for (int k = 1; k < 4; k++) begin
      wr(OFS_STEER, {24'h0, 2'(k), 6'h0});
      cyc(3);
      pins({4'hf, 4'hf & ~(4'h1 << k)});
    end
    port_out <= 4'h0;
    wr(OFS_STEER, 32'h02);
    cyc(3);
    pins(8'hf2);
    wr(OFS_STEER, 32'h01);
    wr(OFS_DELAY, 32'h05);
    pwm_raw <= 1'b0;
    cyc(4);
    pins(8'hf0);
    pwm_raw <= 1'b1;
    cyc(8);
    pins(8'hf0);
    cyc(5);
    pins(8'hf1);
    wr(OFS_DELAY, 32'h0);
    wr(OFS_STEER, 32'h0f);
    cyc(3);
    pins(8'hff);
    for (int c = 0; c < 8; c++) begin
      ac = 2'(c % 3);
      bd = 2'((c + 1) % 3);
      hit = (c[2] & trig[c][2]) | (c[0] & trig[c][1]) | (c[1] & trig[c][0]);
      wr(OFS_SHUTDOWN, {24'h0, 1'b0, c[2:0], ac, bd});
      {fault_req, cmp1_req, cmp2_req} <= trig[c];
      cyc(3);
      chk({31'h0, flag}, {31'h0, hit});
      if (hit) begin
        pins(sdp(ac, bd));
        wr(OFS_SHUTDOWN, {24'h0, 1'b0, c[2:0], ac, bd});
        rd(OFS_SHUTDOWN, {24'h0, 1'b1, c[2:0], ac, bd});
      end
      {fault_req, cmp1_req, cmp2_req} <= 3'h0;
      cyc(3);
      chk({31'h0, flag}, {31'h0, hit});
      // pair states kept, so a held shutdown shows them
      wr(OFS_SHUTDOWN, {24'h0, 1'b0, c[2:0], ac, bd});
      cyc(3);
      pins(hit ? sdp(ac, bd) : 8'hff);
      pulse(1'b0);
      cyc(3);
      pins(8'hff);
    end
    wr(OFS_TIMERSEL, 32'h01);
    wr(OFS_DELAY, 32'h80);
    wr(OFS_SHUTDOWN, 32'h40);
    fault_req <= 1'b1;
    cyc(3);
    chk({31'h0, flag}, 32'h1);
    fault_req <= 1'b0;
    cyc(3);
    chk({31'h0, flag}, 32'h0);
    pulse(1'b0);
    cyc(3);
    pins(8'hf0);
    pulse(1'b1);
    cyc(3);
    pins(8'hff);
    tally_and_finish();
  end
endmodule
